// file: core/brc_defines.vh
// constants for the buck rail control register bank
// Summary of operation
// - Bits 6:5 pick a GPIO whose rising level selects target voltage A and falling selects B.
// - A GPIO-select code of 00 leaves sequencer control, 01 picks GPIO1, 10 GPIO2, 11 GPIO13.
// - Bits 2:1 pick a GPIO whose rising level turns the buck on and falling turns it off.
// - Bit 3 is the enable state the sequencer writes into bit 0 when it runs.
// - Bit 0 switches the converter directly, 0 off and 1 on.
// - Bit 4 of the first core register closes the core rail switch when 1 and opens it when 0.
// - Bit 7 of the first core register is the switch state the sequencer applies to bit 4.
// - In dual-phase mode the second core register has no effect on any converter output, though it still reads back.
// - The switch charge pump runs always, or in auto mode starts before closing and stops after opening.
`ifndef BRC_DEFINES_VH
`define BRC_DEFINES_VH

// register indices; byte address is four times the index
`define BRC_IDX_CORE2     8'h20
`define BRC_IDX_CORE1     8'h21
`define BRC_IDX_PROC      8'h22
`define BRC_IDX_MODE      8'h30
`define BRC_IDX_STATUS    8'h31

// field positions inside a buck control register
`define BRC_BIT_ON        0
`define BRC_ENSEL_LO      1
`define BRC_ENSEL_HI      2
`define BRC_BIT_SEQ       3
`define BRC_BIT_SW        4
`define BRC_VSEL_LO       5
`define BRC_VSEL_HI       6
`define BRC_BIT_SW_SEQ    7

// gpio select codes
`define BRC_SEL_SEQ       2'h0
`define BRC_SEL_GPIO1     2'h1
`define BRC_SEL_GPIO2     2'h2
`define BRC_SEL_GPIO13    2'h3

// writable masks: reserved bits 7 and 4 read as zero except in the first core register
`define BRC_MASK_PLAIN    8'h6f
`define BRC_MASK_CORE1    8'hff
`define BRC_MASK_MODE     8'h03

// mode register fields
`define BRC_BIT_CP_AUTO   0
`define BRC_BIT_DUAL      1

// reset values
`define BRC_RST_CTRL      8'h00
`define BRC_RST_MODE      8'h00

`endif

// file: core/brc_gpio_sync.v
// two-flop synchroniser and edge detector for the three control gpio pins
`timescale 1ns/10ps
module brc_gpio_sync (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       ce,
	input  wire [2:0] gpio_in,
	output reg  [2:0] rise,
	output reg  [2:0] fall
);
	reg [2:0] meta_reg;
	reg [2:0] sync_reg;
	reg [2:0] last_reg;

	// first stage feeds only the second; edges are taken after the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			last_reg <= 3'h0;
			rise     <= 3'h0;
			fall     <= 3'h0;
		end else if (ce) begin
			meta_reg <= gpio_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			rise     <= sync_reg & ~last_reg;
			fall     <= ~sync_reg & last_reg;
		end
	end
endmodule

// file: core/brc_rail_ctrl.v
// buck rail control register bank with apb slave, gpio and sequencer control
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "brc_defines.vh"
module brc_rail_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        gpio1,
	input  wire        gpio2,
	input  wire        gpio13,
	input  wire        seq_run,
	output reg         core2_buck_on,
	output reg         core1_buck_on,
	output reg         processor_buck_on,
	output reg         core2_voltage_a,
	output reg         core1_voltage_a,
	output reg         processor_voltage_a,
	output reg         core_rail_switch,
	output reg         charge_pump_on
);
	reg  [7:0] core2_ctrl_reg;
	reg  [7:0] core1_ctrl_reg;
	reg  [7:0] proc_ctrl_reg;
	reg  [7:0] mode_reg;
	reg        core2_va_reg;
	reg        core1_va_reg;
	reg        proc_va_reg;
	reg  [7:0] core2_ctrl_next;
	reg  [7:0] core1_ctrl_next;
	reg  [7:0] proc_ctrl_next;
	reg  [7:0] rd_next;
	reg        hit_next;
	wire [2:0] g_rise;
	wire [2:0] g_fall;
	wire       setup_cyc;
	wire       access_done;
	wire       wr_en;
	wire [7:0] idx;
	wire       dual;
	wire       cp_auto;
	wire       sw_req;

	// gpio pins come from outside the clock domain
	brc_gpio_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.gpio_in ({gpio13, gpio2, gpio1}),
		.rise    (g_rise),
		.fall    (g_fall)
	);

	// pick the edge of the gpio named by a select code; 00 picks none
	function pick;
		input [1:0] sel;
		input [2:0] ev;
		begin
			case (sel)
				`BRC_SEL_GPIO1:  pick = ev[0];
				`BRC_SEL_GPIO2:  pick = ev[1];
				`BRC_SEL_GPIO13: pick = ev[2];
				default:         pick = 1'b0;
			endcase
		end
	endfunction

	// next control register value: software write, then sequencer, then gpio edges
	function [7:0] rail_next;
		input [7:0] cur;
		input       wr;
		input [7:0] wdata;
		input [7:0] mask;
		input       seq;
		input       has_sw;
		input [2:0] rs;
		input [2:0] fl;
		reg   [7:0] n;
		reg   [1:0] es;
		begin
			n  = wr ? (wdata & mask) : cur;
			es = n[`BRC_ENSEL_HI:`BRC_ENSEL_LO];
			if (seq && es == `BRC_SEL_SEQ)
				n[`BRC_BIT_ON] = n[`BRC_BIT_SEQ];
			if (seq && has_sw)
				n[`BRC_BIT_SW] = n[`BRC_BIT_SW_SEQ];
			if (pick(es, rs))
				n[`BRC_BIT_ON] = 1'b1;
			if (pick(es, fl))
				n[`BRC_BIT_ON] = 1'b0;
			rail_next = n;
		end
	endfunction

	// voltage target: rising edge of the chosen gpio selects a, falling selects b
	function volt_next;
		input       cur;
		input [7:0] ctrl;
		input [2:0] rs;
		input [2:0] fl;
		begin
			volt_next = cur;
			if (pick(ctrl[`BRC_VSEL_HI:`BRC_VSEL_LO], rs))
				volt_next = 1'b1;
			if (pick(ctrl[`BRC_VSEL_HI:`BRC_VSEL_LO], fl))
				volt_next = 1'b0;
		end
	endfunction

	// bus decode; a refused write is masked out of wr_en, so an error access changes nothing
	// and the status word can never be overwritten by software
	assign setup_cyc   = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_en       = access_done & pwrite & ~pslverr;
	assign idx         = paddr[9:2];
	assign dual        = mode_reg[`BRC_BIT_DUAL];
	assign cp_auto     = mode_reg[`BRC_BIT_CP_AUTO];
	assign sw_req      = core1_ctrl_reg[`BRC_BIT_SW];

	// register next values; hardware events are applied after the write so they win
	always @* begin
		core2_ctrl_next = rail_next(core2_ctrl_reg, wr_en && idx == `BRC_IDX_CORE2,
			pwdata[7:0], `BRC_MASK_PLAIN, seq_run, 1'b0, g_rise, g_fall);
		core1_ctrl_next = rail_next(core1_ctrl_reg, wr_en && idx == `BRC_IDX_CORE1,
			pwdata[7:0], `BRC_MASK_CORE1, seq_run, 1'b1, g_rise, g_fall);
		proc_ctrl_next  = rail_next(proc_ctrl_reg, wr_en && idx == `BRC_IDX_PROC,
			pwdata[7:0], `BRC_MASK_PLAIN, seq_run, 1'b0, g_rise, g_fall);
	end

	// read decode; the address must be word aligned and inside the map
	always @* begin
		rd_next  = 8'h00;
		hit_next = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
		case (idx)
			`BRC_IDX_CORE2:  rd_next = core2_ctrl_reg;
			`BRC_IDX_CORE1:  rd_next = core1_ctrl_reg;
			`BRC_IDX_PROC:   rd_next = proc_ctrl_reg;
			`BRC_IDX_MODE:   rd_next = mode_reg;
			`BRC_IDX_STATUS: rd_next = {core_rail_switch, charge_pump_on,
				processor_voltage_a, core1_voltage_a, core2_voltage_a,
				processor_buck_on, core1_buck_on, core2_buck_on};
			default:         hit_next = 1'b0;
		endcase
	end

	// apb slave: answer is registered in the setup cycle, so no wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready <= setup_cyc;
			if (setup_cyc) begin
				pslverr <= ~hit_next | (pwrite & (idx == `BRC_IDX_STATUS));
				prdata  <= (pwrite | ~hit_next) ? 32'h0000_0000 : {24'h00_0000, rd_next};
			end else if (access_done) begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
		end
	end

	// control registers; every gpio select resets to sequencer control
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core2_ctrl_reg <= `BRC_RST_CTRL;
			core1_ctrl_reg <= `BRC_RST_CTRL;
			proc_ctrl_reg  <= `BRC_RST_CTRL;
			mode_reg       <= `BRC_RST_MODE;
			core2_va_reg   <= 1'b0;
			core1_va_reg   <= 1'b0;
			proc_va_reg    <= 1'b0;
		end else if (ce) begin
			core2_ctrl_reg <= core2_ctrl_next;
			core1_ctrl_reg <= core1_ctrl_next;
			proc_ctrl_reg  <= proc_ctrl_next;
			if (wr_en && idx == `BRC_IDX_MODE)
				mode_reg <= pwdata[7:0] & `BRC_MASK_MODE;
			core2_va_reg <= volt_next(core2_va_reg, core2_ctrl_reg, g_rise, g_fall);
			core1_va_reg <= volt_next(core1_va_reg, core1_ctrl_reg, g_rise, g_fall);
			proc_va_reg  <= volt_next(proc_va_reg, proc_ctrl_reg, g_rise, g_fall);
		end
	end

	// converter outputs; in dual phase the second core phase just follows the first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core2_buck_on       <= 1'b0;
			core1_buck_on       <= 1'b0;
			processor_buck_on   <= 1'b0;
			core2_voltage_a     <= 1'b0;
			core1_voltage_a     <= 1'b0;
			processor_voltage_a <= 1'b0;
		end else if (ce) begin
			core1_buck_on     <= core1_ctrl_reg[`BRC_BIT_ON];
			processor_buck_on <= proc_ctrl_reg[`BRC_BIT_ON];
			core2_buck_on     <= dual ? core1_ctrl_reg[`BRC_BIT_ON] :
				core2_ctrl_reg[`BRC_BIT_ON];
			core1_voltage_a     <= core1_va_reg;
			processor_voltage_a <= proc_va_reg;
			core2_voltage_a     <= dual ? core1_va_reg : core2_va_reg;
		end
	end

	// charge pump runs always, or in auto mode leads the switch closing and trails its opening by one cycle,
	// which keeps the switch gate from being driven without pump supply
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_rail_switch <= 1'b0;
			charge_pump_on   <= 1'b1;
		end else if (ce) begin
			charge_pump_on   <= ~cp_auto | sw_req | core_rail_switch;
			core_rail_switch <= sw_req & charge_pump_on;
		end
	end
endmodule

// file: testbench/brc_rail_chk.sv
// assertion checker for the buck rail control register bank
`timescale 1ns/10ps
module brc_rail_chk (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        seq_run,
	input logic        core1_buck_on,
	input logic        core_rail_switch,
	input logic        charge_pump_on
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup and completed access phases
	wire setup = psel && !penable;
	wire acc   = psel && penable && pready;
	a_ready_setup: assert property (setup |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_err_unmapped: assert property (setup && paddr[9:2] == 8'h23 |=> pslverr)
		else $error("unmapped index not refused");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_switch_pump: assert property (core_rail_switch |-> charge_pump_on)
		else $error("switch closed without pump");
	a_pump_first: assert property ($rose(core_rail_switch) |-> $past(charge_pump_on))
		else $error("pump not started before closing");
	a_pump_after: assert property ($fell(charge_pump_on) |-> !$past(core_rail_switch))
		else $error("pump stopped while closed");
	// ensel 00 leaves bit 0 to software; output follows two edges after the access
	a_write_on: assert property (acc && pwrite && paddr == 32'h84 && pwdata[2:1] == 2'h0
		&& !seq_run |=> ##1 core1_buck_on == $past(pwdata[0], 2))
		else $error("enable write not applied");
	c_write: cover property (acc && pwrite);
	c_error: cover property (pready && pslverr);
	c_switch: cover property ($rose(core_rail_switch));
endmodule
bind brc_rail_ctrl brc_rail_chk u_chk (
	.pclk             (pclk),
	.presetn          (presetn),
	.psel             (psel),
	.penable          (penable),
	.pwrite           (pwrite),
	.paddr            (paddr),
	.pwdata           (pwdata),
	.prdata           (prdata),
	.pready           (pready),
	.pslverr          (pslverr),
	.seq_run          (seq_run),
	.core1_buck_on    (core1_buck_on),
	.core_rail_switch (core_rail_switch),
	.charge_pump_on   (charge_pump_on)
);

// file: testbench/brc_far_model.sv
// far-side model: control gpio pins and sequencer run pulse
`timescale 1ns/10ps
module brc_far_model (
	input  logic pclk,
	output logic gpio1,
	output logic gpio2,
	output logic gpio13,
	output logic seq_run
);
	initial {gpio1, gpio2, gpio13, seq_run} = 4'h0;
	// code 00 still moves gpio1, so an ignored pin is really toggled
	task set_pin(input logic [1:0] c, input logic v);
		@(posedge pclk);
		case (c)
			2'h2: gpio2 <= v;
			2'h3: gpio13 <= v;
			default: gpio1 <= v;
		endcase
	endtask
	// one-cycle run pulse on the shared clock
	task pulse_seq;
		@(posedge pclk) seq_run <= 1'b1;
		@(posedge pclk) seq_run <= 1'b0;
	endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the buck rail control register bank
`timescale 1ns/10ps
`include "brc_defines.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        gpio1, gpio2, gpio13, seq_run, c2_on, c1_on, pr_on, pr_va, sw, pump;
	logic        ce, c2_va, c1_va;
	logic [7:0]  d, idx;
	int          error_cnt, tests_run;
	brc_rail_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gpio1(gpio1), .gpio2(gpio2), .gpio13(gpio13),
		.seq_run(seq_run), .core2_buck_on(c2_on), .core1_buck_on(c1_on),
		.processor_buck_on(pr_on), .core2_voltage_a(c2_va), .core1_voltage_a(c1_va),
		.processor_voltage_a(pr_va), .core_rail_switch(sw), .charge_pump_on(pump));
	brc_far_model u_far (.pclk(pclk), .gpio1(gpio1), .gpio2(gpio2), .gpio13(gpio13),
		.seq_run(seq_run));
	function [31:0] adr(input [7:0] i); return {22'h0, i, 2'h0}; endfunction
	// reserved bits 7 and 4 exist only in the first core register
	function [7:0] msk(input [7:0] i); return i == `BRC_IDX_CORE1 ? 8'hff : 8'h6f; endfunction
	task end_sim;
		if (error_cnt == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task cyc(input int n); repeat (n) @(posedge pclk); endtask
	// one apb transfer, entered just after an edge; a hang ends the run
	task apb(input logic w, input logic [31:0] a, input logic [7:0] dd);
		int n;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, dd};
		@(posedge pclk) penable <= 1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			end_sim;
		end else begin
			rd = prdata; err = pslverr; psel <= 0; penable <= 0;
			@(posedge pclk);
		end
	endtask
	initial begin pclk = 0; forever #20 pclk = ~pclk; end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, error_cnt, tests_run} = 0;
		ce = 1'b1;
		d = $urandom(32'h04bd);
		cyc(12);
		presetn <= 1;
		@(posedge pclk);
		// reset contents and static pump
		for (int i = 0; i < 3; i++) begin
			apb(0, adr(8'(`BRC_IDX_CORE2 + i)), 0);
			`CHK("reset value", 32'h0, rd)
			`CHK("no error", 1'b0, err)
		end
		apb(0, adr(`BRC_IDX_STATUS), 0);
		`CHK("status", 32'h40, rd)
		// random writes, read back and enable outputs via status
		for (int i = 0; i < 12; i++) begin
			d = $urandom;
			idx = 8'(`BRC_IDX_CORE2 + i % 3);
			apb(1, adr(idx), d);
			apb(0, adr(idx), 0);
			`CHK("readback", {24'h0, d & msk(idx)}, rd)
			apb(0, adr(`BRC_IDX_STATUS), 0);
			`CHK("buck on", d[0], rd[i % 3])
			if (i % 3 == 1) `CHK("switch", d[4], rd[7])
		end
		// each select code on both fields of all three rail registers
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 3; k++)
				apb(1, adr(8'(`BRC_IDX_CORE2 + k)), 8'(c << 5 | c << 1));
			u_far.set_pin(2'(c), 1);
			cyc(10);
			`CHK("gpio on", c != 0, pr_on)
			`CHK("gpio volt a", c != 0, pr_va)
			`CHK("core1 gpio on", c != 0, c1_on)
			`CHK("core2 gpio on", c != 0, c2_on)
			`CHK("core1 volt a", c != 0, c1_va)
			`CHK("core2 volt a", c != 0, c2_va)
			u_far.set_pin(2'(c), 0);
			cyc(10);
			`CHK("gpio off", 1'b0, pr_on)
			`CHK("gpio volt b", 1'b0, pr_va)
		end
		// clock enable low freezes the synchroniser, so a pin edge waits until it returns
		ce <= 0;
		u_far.set_pin(2'h3, 1);
		cyc(10);
		`CHK("frozen", 1'b0, pr_on)
		ce <= 1;
		cyc(10);
		`CHK("thawed", 1'b1, pr_on)
		u_far.set_pin(2'h3, 0);
		cyc(10);
		// sequencer applies stored targets
		apb(1, adr(`BRC_IDX_CORE1), 8'h88);
		u_far.pulse_seq;
		cyc(4);
		`CHK("seq on", 1'b1, c1_on)
		`CHK("seq switch", 1'b1, sw)
		// automatic pump follows the switch
		apb(1, adr(`BRC_IDX_MODE), 8'h01);
		apb(1, adr(`BRC_IDX_CORE1), 8'h00);
		cyc(3);
		`CHK("switch open", 1'b0, sw)
		`CHK("pump off", 1'b0, pump)
		apb(1, adr(`BRC_IDX_CORE1), 8'h10);
		cyc(3);
		`CHK("switch closed", 1'b1, sw)
		`CHK("pump on", 1'b1, pump)
		// dual phase: second core register ignored
		apb(1, adr(`BRC_IDX_MODE), 8'h02);
		apb(1, adr(`BRC_IDX_CORE2), 8'h01);
		apb(1, adr(`BRC_IDX_CORE1), 8'h00);
		cyc(2);
		`CHK("dual off", 1'b0, c2_on)
		apb(1, adr(`BRC_IDX_CORE1), 8'h01);
		cyc(2);
		`CHK("dual on", 1'b1, c2_on)
		// a mid-run reset returns every select to sequencer control
		presetn <= 0;
		cyc(2);
		presetn <= 1;
		@(posedge pclk);
		apb(0, adr(`BRC_IDX_CORE1), 0);
		`CHK("reset again", 32'h0, rd)
		apb(1, adr(`BRC_IDX_STATUS), 8'hff);
		`CHK("status write refused", 1'b1, err)
		apb(0, 32'h8c, 0);
		`CHK("unmapped refused", 1'b1, err)
		end_sim;
	end
endmodule
